// ==== etn_pkg.sv ====
// Package for the E3 transmit nibble payload port
package etn_pkg;
  localparam logic [7:0] ETN_ADDR_MODE = 8'h00;
  localparam logic [7:0] ETN_ADDR_STATUS = 8'h01;
  localparam logic [7:0] ETN_ADDR_NIBBLE = 8'h02;
  localparam logic [7:0] ETN_ADDR_COUNT = 8'h03;
  // Mode register fields
  localparam int ETN_TRS_LSB = 0;
  localparam int ETN_FMT_BIT = 2;
  localparam int ETN_STD_BIT = 6;
  localparam logic [7:0] ETN_MODE_RESET = 8'h29;
  localparam logic [1:0] ETN_TRS_FRAME_REF = 2'h1;
  // Timing
  localparam int ETN_CLK_DIV = 4;
  localparam int ETN_SAMPLE_EDGE = 3;
  localparam int ETN_FRAME_BITS = 1536;
  localparam int ETN_FRAME_NIBBLES = ETN_FRAME_BITS / 4;
  localparam real ETN_REF_MHZ = 34.368;
  localparam real ETN_NIB_MHZ = ETN_REF_MHZ / ETN_CLK_DIV;
  localparam int ETN_FIFO_WIDTH = 4;
  localparam int ETN_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    ETN_MODE_OFF,
    ETN_MODE_FRAME_REF,
    ETN_MODE_LOCAL
  } etn_mode_t;

  typedef struct packed {
    logic [1:0] timing_reference_select;
    logic frame_format;
    logic line_standard_select;
  } etn_cfg_t;

  function automatic etn_mode_t etn_decode(input logic strap,
                                           input logic [1:0] trs);
    if (!strap) begin
      return ETN_MODE_OFF;
    end else if (trs[1]) begin
      return ETN_MODE_LOCAL;
    end else if (trs == ETN_TRS_FRAME_REF) begin
      return ETN_MODE_FRAME_REF;
    end
    return ETN_MODE_OFF;
  endfunction
endpackage

// ==== etn_fifo.sv ====
// Small parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module etn_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== etn_port.sv ====
// Transmit payload nibble port of one E3 framer channel
`timescale 1ns/1ps
// How it works
// - Divide reference clock by four, drive out
// - Capture payload nibbles each nibble clock
// - Frames start in frame-reference mode, aligned by the external pulse
// - Marker high one bit, frame last bit
// - Sample on third reference edge after nibble clock rise
// - Nibble clock is quarter of reference
// - Overhead internal, overhead indicator held low
module etn_port
  import etn_pkg::*;
(
  // Clock and reset; clock is the transmit reference clock
  input wire logic clock,
  input wire logic rst,
  // Configuration strap
  input wire logic parallel_interface_strap,
  // Terminal equipment side
  input wire logic [3:0] tx_payload_nibble_in,
  input wire logic tx_frame_reference_in,
  output logic tx_quarter_rate_clock_out,
  output logic tx_last_bit_marker,
  output logic tx_overhead_indicator,
  // Payload toward the framer core
  output logic [3:0] core_nibble,
  output logic core_valid,
  input wire logic core_ready,
  output logic tx_overflow,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata
);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] framer_operating_mode;
  etn_cfg_t cfg;
  etn_mode_t mode;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic [8:0] nib_cnt;
  logic [1:0] bit_cnt;
  logic sample_en;
  logic [3:0] last_nibble;
  logic overflow_sticky;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [3:0] fifo_out_data;
  logic active;

  assign cfg.timing_reference_select =
    framer_operating_mode[ETN_TRS_LSB +: 2];
  assign cfg.frame_format = framer_operating_mode[ETN_FMT_BIT];
  assign cfg.line_standard_select = framer_operating_mode[ETN_STD_BIT];
  assign mode = etn_decode(parallel_interface_strap,
                           cfg.timing_reference_select);
  assign active = (mode != ETN_MODE_OFF);

  always_ff @(posedge clock) begin
    if (rst) begin
      framer_operating_mode <= ETN_MODE_RESET;
    end else if (reg_write && reg_addr == ETN_ADDR_MODE) begin
      framer_operating_mode <= reg_wdata;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ETN_ADDR_MODE: reg_rdata <= framer_operating_mode;
        ETN_ADDR_STATUS: reg_rdata <= {4'h0, overflow_sticky,
                                       fifo_out_valid, mode};
        ETN_ADDR_NIBBLE: reg_rdata <= {4'h0, last_nibble};
        ETN_ADDR_COUNT: reg_rdata <= nib_cnt[8:1];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Quarter rate clock: high for two reference cycles of four. It starts
  // low after reset or enable, so even the first high phase is full width.
  assign next_div_cnt = div_cnt + 2'h1;

  always_ff @(posedge clock) begin
    if (rst || !active) begin
      div_cnt <= 2'h0;
      tx_quarter_rate_clock_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tx_quarter_rate_clock_out <= (next_div_cnt >= 2'(ETN_CLK_DIV / 2));
    end
  end

  // The nibble clock rises as the divider leaves 1; the capture edge is
  // the third one after that, when the divider leaves 0. The far end moves
  // its data one edge after the rise, so sampling late gives it margin.
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      sample_en <= 1'b0;
    end else begin
      sample_en <= (div_cnt == 2'(ETN_SAMPLE_EDGE));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Nibble capture into the FIFO
  always_ff @(posedge clock) begin
    if (rst) begin
      last_nibble <= 4'h0;
    end else if (sample_en) begin
      last_nibble <= tx_payload_nibble_in;
    end
  end

  // Payload cannot be paused, so a full FIFO drops and flags
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_sticky <= 1'b0;
    end else if (sample_en && !fifo_in_ready) begin
      overflow_sticky <= 1'b1;
    end else if (reg_read && reg_addr == ETN_ADDR_STATUS) begin
      overflow_sticky <= 1'b0;
    end
  end

  etn_fifo #(
    .WIDTH(ETN_FIFO_WIDTH),
    .DEPTH(ETN_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(sample_en),
    .in_ready(fifo_in_ready),
    .in_data(tx_payload_nibble_in),
    .out_valid(fifo_out_valid),
    .out_ready(core_ready || !core_valid),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      core_valid <= 1'b0;
      core_nibble <= 4'h0;
    end else if (core_ready || !core_valid) begin
      core_valid <= fifo_out_valid;
      core_nibble <= fifo_out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_overflow <= 1'b0;
    end else begin
      tx_overflow <= overflow_sticky;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame timing: free running in local mode, realigned by the
  // reference pulse in frame-reference mode.
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      nib_cnt <= 9'h000;
      bit_cnt <= 2'h0;
    end else if (mode == ETN_MODE_FRAME_REF && tx_frame_reference_in) begin
      nib_cnt <= 9'h000;
      bit_cnt <= 2'h0;
    end else begin
      bit_cnt <= bit_cnt + 2'h1;
      if (bit_cnt == 2'h3) begin
        nib_cnt <= (nib_cnt == 9'(ETN_FRAME_NIBBLES - 1)) ?
                   9'h000 : nib_cnt + 9'h001;
      end
    end
  end

  // One reference cycle equals one line bit period
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      tx_last_bit_marker <= 1'b0;
    end else begin
      tx_last_bit_marker <= (nib_cnt == 9'(ETN_FRAME_NIBBLES - 1)) &&
                            (bit_cnt == 2'h2);
    end
  end

  // Overhead is always internal in E3 nibble mode
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_overhead_indicator <= 1'b0;
    end else begin
      tx_overhead_indicator <= 1'b0;
    end
  end
endmodule

// ==== etn_port_sva.sv ====
// Assertion checker for the transmit nibble port
`timescale 1ns/1ps
module etn_port_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Port signals
  input wire logic parallel_interface_strap,
  input wire logic tx_frame_reference_in,
  input wire logic tx_quarter_rate_clock_out,
  input wire logic tx_last_bit_marker,
  input wire logic tx_overhead_indicator,
  input wire logic [3:0] core_nibble,
  input wire logic core_valid,
  input wire logic core_ready,
  input wire logic tx_overflow,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [10:0] gap;
  logic seen;
  logic stat_rd_q;
  // Reading status clears the flag, the pin follows one cycle later
  always_ff @(posedge clock) begin
    stat_rd_q <= reg_read && (reg_addr == 8'h01);
  end
  // An external frame pulse in frame-reference mode or a disabled port moves the boundary
  always_ff @(posedge clock) begin
    if (rst || tx_frame_reference_in || !parallel_interface_strap) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else if (tx_last_bit_marker) begin
      gap <= 11'h000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 11'h001;
    end
  end
  ////////////////////////
  chk_ovh_low: assert property (
    tx_overhead_indicator == 1'b0) else $error("overhead flag high");
  chk_div_high: assert property (
    disable iff (rst || !parallel_interface_strap)
    $rose(tx_quarter_rate_clock_out) |=> tx_quarter_rate_clock_out
    ##1 !tx_quarter_rate_clock_out) else $error("nibble clock high");
  chk_div_low: assert property (
    disable iff (rst || !parallel_interface_strap)
    $fell(tx_quarter_rate_clock_out) |=> !tx_quarter_rate_clock_out
    ##1 tx_quarter_rate_clock_out) else $error("nibble clock low");
  chk_mark_once: assert property (
    tx_last_bit_marker |=> !tx_last_bit_marker) else $error("long marker");
  chk_mark_gap: assert property (
    tx_last_bit_marker && seen |-> gap == 11'h5FF) else $error("frame gap");
  chk_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 8'h00) else $error("read data not idle");
  chk_stream_hold: assert property (
    core_valid && !core_ready |=> core_valid && $stable(core_nibble))
    else $error("stream dropped");
  chk_ovf_sticky: assert property (
    tx_overflow && !(reg_read && reg_addr == 8'h01) && !stat_rd_q
    |=> tx_overflow)
    else $error("overflow lost");
  cover property (tx_last_bit_marker);
  cover property (core_valid && !core_ready);
  cover property (tx_overflow);
endmodule
bind etn_port etn_port_sva etn_port_sva_i (.clock, .rst,
  .parallel_interface_strap,
  .tx_frame_reference_in, .tx_quarter_rate_clock_out, .tx_last_bit_marker,
  .tx_overhead_indicator, .core_nibble, .core_valid, .core_ready,
  .tx_overflow, .reg_addr, .reg_read, .reg_rdata);

// ==== etn_term.sv ====
// Terminal equipment model feeding counting payload nibbles
`timescale 1ns/1ps
module etn_term (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Device side
  input wire logic nib_clk,
  output logic [3:0] nib
);
  logic nib_clk_q;
  always_ff @(posedge clock) begin
    nib_clk_q <= nib_clk;
    if (rst) begin
      nib <= 4'h0;
    end else if (nib_clk && !nib_clk_q) begin
      nib <= nib + 4'h1;
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the transmit nibble port
`timescale 1ns/1ps
module tb_top;
  import etn_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic ref_in = 1'b0;
  logic cr = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic q_clk, mark, ovh, cv, ovf;
  logic [3:0] nib, cn, n, prev;
  logic [7:0] rdata, d;
  int n_errors = 0;
  int n_tests = 0;
  int k, c;
  always #5 clock = ~clock;
  etn_term etn_term_i (.clock, .rst, .nib_clk(q_clk), .nib(nib));
  etn_port etn_port_i (.clock, .rst, .parallel_interface_strap(strap),
    .tx_payload_nibble_in(nib), .tx_frame_reference_in(ref_in),
    .tx_quarter_rate_clock_out(q_clk), .tx_last_bit_marker(mark),
    .tx_overhead_indicator(ovh), .core_nibble(cn), .core_valid(cv),
    .core_ready(cr), .tx_overflow(ovf), .reg_addr(addr), .reg_wdata(wd),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata));
  ////////////////////////
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // Sampled at the falling edge so the taking edge has not yet moved it
  task automatic get(output logic [3:0] v);
    for (k = 0; k < 200; k++) begin
      @(negedge clock);
      if (cv === 1'b1) break;
    end
    if (k == 200) begin
      n_errors++;
      give_verdict();
    end
    v = cn;
  endtask
  task automatic run(input int cnt);
    get(prev);
    for (int i = 1; i < cnt; i++) begin
      get(n);
      check8("nibble", {4'h0, prev + 4'h1}, {4'h0, n});
      prev = n;
    end
  endtask
  task automatic wait_mark();
    for (c = 1; c < 1700; c++) begin
      @(negedge clock);
      if (mark === 1'b1) break;
    end
    if (c == 1700) begin
      n_errors++;
      give_verdict();
    end
  endtask
  ////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(ETN_ADDR_MODE, d);
    check8("mode reset", ETN_MODE_RESET, d);
    rd(8'h3C, d);
    check8("unmapped", 8'h00, d);
    wr(ETN_ADDR_NIBBLE, 8'hFF);
    wr(ETN_ADDR_MODE, 8'h2B);
    rd(ETN_ADDR_MODE, d);
    check8("mode rw", 8'h2B, d);
    rd(ETN_ADDR_STATUS, d);
    check8("local", 8'h02, d & 8'h03);
    run(20);
    wait_mark();
    wait_mark();
    check8("frame gap", 8'h01, {7'h00, c == 1536});
    check8("overhead", 8'h00, {7'h00, ovh});
    // Stop intake after the stall, else drops re-arm the flag at once
    @(posedge clock);
    cr <= 1'b0;
    repeat (100) @(posedge clock);
    strap <= 1'b0;
    repeat (4) @(posedge clock);
    check8("ovf pin", 8'h01, {7'h00, ovf});
    rd(ETN_ADDR_STATUS, d);
    check8("ovf set", 8'h08, d & 8'h0B);
    rd(ETN_ADDR_STATUS, d);
    check8("ovf clr", 8'h00, d & 8'h08);
    @(posedge clock);
    cr <= 1'b1;
    strap <= 1'b1;
    run(8);
    wr(ETN_ADDR_MODE, 8'h01);
    rd(ETN_ADDR_STATUS, d);
    check8("ref mode", 8'h01, d & 8'h03);
    // Realign mid-frame: the next marker must follow the pulse by a frame
    wait_mark();
    repeat (100) @(posedge clock);
    ref_in <= 1'b1;
    @(posedge clock);
    ref_in <= 1'b0;
    wait_mark();
    check8("realign", 8'h01, {7'h00, c == 1536});
    give_verdict();
  end
endmodule
